// ==== logic/uart_pkg.sv ====
package uart_pkg;
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_LAST = 5'h10;
  localparam int FIFO_DEPTH = 8;
  localparam int WORD_W = 9;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] VOTE_FIRST = 4'h7;
  localparam logic [3:0] VOTE_LAST = 4'h9;
  localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
  localparam logic [3:0] DIVISOR_RESET = 4'h0;
  localparam logic [1:0] CMD_WR_CFG = 2'h3;
  localparam logic [1:0] CMD_RD_CFG = 2'h1;
  localparam logic [1:0] CMD_WR_DATA = 2'h2;
  localparam logic [1:0] CMD_RD_DATA = 2'h0;
  localparam int BIT_INHIBIT = 10;
  localparam int BIT_RTS = 9;
  localparam int BIT_EXTRA = 8;
  localparam int BIT_TEST = 0;

  typedef struct packed {
    logic fifo_disable_n;
    logic sleep_request_bit;
    logic tx_empty_irq_mask;
    logic rx_ready_irq_mask;
    logic extra_bit_irq_mask;
    logic activity_irq_mask;
    logic infrared_timing_sel;
    logic stop_bits_sel;
    logic extra_bit_enable;
    logic short_word;
    logic [3:0] divisor_select;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{divisor_select: DIVISOR_RESET, default: 1'b0};

  typedef struct packed {
    logic rx_extra_bit;
    logic [7:0] rx_byte;
  } rx_word_t;

  typedef struct packed {
    logic ready;
    logic tx_empty;
    logic [2:0] zero;
    logic activity_or_frame_error;
    logic cts;
    rx_word_t word;
  } status_t;
endpackage

// ==== logic/rx_fifo.sv ====
`timescale 1ns/1ps
module rx_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control.
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic flush_i,
  input wire logic one_deep_i,
  input wire logic [W-1:0] wdata_i,
  // State.
  output logic [W-1:0] rdata_o,
  output logic empty_o,
  output logic full_o,
  output logic [$clog2(D+1)-1:0] count_o
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D+1);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count;
  logic do_push, do_pop;

  assign empty_o = count == '0;
  // With the buffer disabled a single word is held.
  assign full_o = one_deep_i ? !empty_o : count == CW'(D);
  assign count_o = count;
  assign rdata_o = empty_o ? '0 : mem[rd_ptr];
  assign do_push = push_i && !full_o;
  assign do_pop = pop_i && !empty_o;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (flush_i) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
    end else begin
      if (do_push) next_wr_ptr = (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + AW'(1);
      if (do_pop) next_rd_ptr = (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + AW'(1);
      next_count = count + CW'(do_push) - CW'(do_pop);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge clk_i) begin
    if (do_push && !flush_i) mem[wr_ptr] <= wdata_i;
  end
endmodule // rx_fifo

// ==== logic/baud_gen.sv ====
`timescale 1ns/1ps
module baud_gen #(
  parameter int DW = 16
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Oscillator samples and setting.
  input wire logic osc_rise_i,
  input wire logic osc_level_i,
  input wire logic hold_i,
  input wire logic [3:0] divisor_select_i,
  // Baud outputs.
  output logic tick_o,
  output logic clk16_o
);
  logic [DW-1:0] count, next_count, div;
  logic next_tick, next_clk16;

  // The divisor is a power of two chosen by the select field.
  assign div = DW'(1) << divisor_select_i;

  always_comb begin
    next_count = count;
    next_tick = 1'b0;
    if (hold_i) begin
      next_count = '0;
    end else if (osc_rise_i) begin
      if (count == div - DW'(1)) begin
        next_count = '0;
        next_tick = 1'b1;
      end else begin
        next_count = count + DW'(1);
      end
    end
    next_clk16 = (divisor_select_i == 4'h0) ? osc_level_i : (next_count < (div >> 1));
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count <= '0;
      tick_o <= 1'b0;
      clk16_o <= 1'b0;
    end else begin
      count <= next_count;
      tick_o <= next_tick;
      clk16_o <= next_clk16;
    end
  end
endmodule // baud_gen

// ==== logic/serial_host_uart.sv ====
`timescale 1ns/1ps
module serial_host_uart (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Host command port.
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  // Interrupt, open drain.
  output logic irq_n_o,
  output logic irq_oe_o,
  // Serial link and handshake.
  input wire logic oscillator_input_i,
  input wire logic rx_i,
  output logic tx_o,
  input wire logic cts_n_i,
  output logic rts_n_o
);
  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
  typedef enum logic {RX_IDLE, RX_RUN} rx_state_t;

  logic [5:0] pins, meta, sync, prev;
  logic sclk_rise, sclk_fall, cs_rise, cs_fall, osc_rise, rx_in;
  logic tick, clk16;

  assign pins = {oscillator_input_i, rx_i, cts_n_i, din_i, cs_n_i, sclk_i};
  for (genvar i = 0; i < 6; i++) begin : g_sync
    always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
        meta[i] <= 1'b1;
        sync[i] <= 1'b1;
        prev[i] <= 1'b1;
      end else begin
        meta[i] <= pins[i];
        sync[i] <= meta[i];
        prev[i] <= sync[i];
      end
    end
  end
  assign sclk_rise = sync[0] && !prev[0];
  assign sclk_fall = !sync[0] && prev[0];
  assign cs_fall = !sync[1] && prev[1];
  assign cs_rise = sync[1] && !prev[1];
  assign osc_rise = sync[5] && !prev[5];

  // Command port.
  logic [15:0] in_sr, next_in_sr, out_sr, next_out_sr, word;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic active, next_active, frame_done, mask_load;
  logic [13:0] reply;
  logic [1:0] cmd;
  uart_pkg::status_t status;
  uart_pkg::cfg_t cfg_wr, next_cfg_wr, cfg_act, next_cfg_act, readback;

  assign cmd = in_sr[15:14];
  assign word = in_sr;
  assign frame_done = cs_rise && active && bit_cnt == uart_pkg::FRAME_LAST;
  assign mask_load = active && sclk_rise && bit_cnt == 5'hF && in_sr[14:13] == uart_pkg::CMD_WR_CFG;

  always_comb begin
    readback = cfg_wr;
    readback.sleep_request_bit = cfg_act.sleep_request_bit;
    readback.tx_empty_irq_mask = cfg_act.tx_empty_irq_mask;
    readback.rx_ready_irq_mask = cfg_act.rx_ready_irq_mask;
    readback.extra_bit_irq_mask = cfg_act.extra_bit_irq_mask;
    readback.activity_irq_mask = cfg_act.activity_irq_mask;
    case (in_sr[1:0])
      uart_pkg::CMD_RD_CFG: reply = readback;
      uart_pkg::CMD_WR_CFG: reply = '0;
      default: reply = status[13:0];
    endcase
  end

  always_comb begin
    next_in_sr = in_sr;
    next_bit_cnt = bit_cnt;
    next_out_sr = out_sr;
    next_active = active;
    if (cs_fall) begin
      next_active = 1'b1;
      next_bit_cnt = '0;
      next_out_sr = status;
    end else if (cs_rise) begin
      next_active = 1'b0;
    end else if (active && sclk_rise && bit_cnt != uart_pkg::FRAME_LAST) begin
      next_in_sr = {in_sr[14:0], sync[2]};
      next_bit_cnt = bit_cnt + 5'h1;
    end else if (active && sclk_fall && bit_cnt != 5'h0 && bit_cnt != uart_pkg::FRAME_LAST) begin
      next_out_sr = (bit_cnt == 5'h2) ? {reply, 2'h0} : {out_sr[14:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      in_sr <= '0;
      out_sr <= '0;
      bit_cnt <= '0;
      active <= 1'b0;
    end else begin
      in_sr <= next_in_sr;
      out_sr <= next_out_sr;
      bit_cnt <= next_bit_cnt;
      active <= next_active;
    end
  end
  assign dout_o = out_sr[15];
  assign dout_oe_o = active;

  // Control, status and transmit buffer.
  logic cfg_pending, next_cfg_pending, rts, next_rts, test_mode, next_test_mode;
  logic fe, next_fe, tx_full, next_tx_full, irq, next_irq, next_rts_n;
  logic flush, pop, tx_take, tx_busy, rx_push, rx_err, rx_good, ra_event;
  logic fifo_empty, fifo_full;
  logic [3:0] fifo_count;
  uart_pkg::rx_word_t tx_buf, next_tx_buf, rx_word, head;

  assign ra_event = cfg_act.sleep_request_bit && (sync[4] != prev[4]);

  always_comb begin
    next_cfg_wr = cfg_wr;
    next_cfg_act = cfg_act;
    next_cfg_pending = cfg_pending;
    next_rts = rts;
    next_test_mode = test_mode;
    next_fe = fe;
    next_tx_full = tx_full;
    next_tx_buf = tx_buf;
    flush = 1'b0;
    pop = 1'b0;
    // A word loaded while settings wait is held back and then sent with the new settings.
    if (cfg_pending && !tx_busy) begin
      next_cfg_act = cfg_wr;
      next_cfg_act.tx_empty_irq_mask = cfg_act.tx_empty_irq_mask;
      next_cfg_act.rx_ready_irq_mask = cfg_act.rx_ready_irq_mask;
      next_cfg_act.extra_bit_irq_mask = cfg_act.extra_bit_irq_mask;
      next_cfg_act.activity_irq_mask = cfg_act.activity_irq_mask;
      next_cfg_pending = 1'b0;
    end
    if (mask_load) begin
      {next_cfg_act.tx_empty_irq_mask, next_cfg_act.rx_ready_irq_mask,
       next_cfg_act.extra_bit_irq_mask, next_cfg_act.activity_irq_mask} = in_sr[10:7];
    end
    if (tx_take) next_tx_full = 1'b0;
    if (rx_good) next_fe = 1'b0;
    if (frame_done) begin
      case (cmd)
        uart_pkg::CMD_WR_CFG: begin
          next_cfg_wr = word[13:0];
          next_cfg_pending = 1'b1;
          flush = 1'b1;
          next_fe = 1'b0;
          next_tx_full = 1'b0;
        end
        uart_pkg::CMD_RD_CFG: next_test_mode = word[uart_pkg::BIT_TEST];
        uart_pkg::CMD_WR_DATA: begin
          next_rts = word[uart_pkg::BIT_RTS];
          if (!word[uart_pkg::BIT_INHIBIT]) begin
            next_tx_buf = word[8:0];
            next_tx_full = 1'b1;
          end
        end
        default: pop = 1'b1;
      endcase
    end
    if (rx_err || ra_event) next_fe = 1'b1;
    status = '{ready: !fifo_empty, tx_empty: !tx_full, zero: 3'h0,
               activity_or_frame_error: fe, cts: !sync[3], word: head};
    next_irq = (cfg_act.tx_empty_irq_mask && !tx_full) || (cfg_act.rx_ready_irq_mask && !fifo_empty)
      || (cfg_act.extra_bit_irq_mask && head.rx_extra_bit)
      || (cfg_act.activity_irq_mask && fe);
    next_rts_n = (test_mode && !sync[1]) ? clk16 : !next_rts;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cfg_wr <= uart_pkg::CFG_RESET;
      cfg_act <= uart_pkg::CFG_RESET;
      cfg_pending <= 1'b0;
      rts <= 1'b0;
      test_mode <= 1'b0;
      fe <= 1'b0;
      tx_full <= 1'b0;
      tx_buf <= '0;
      irq <= 1'b0;
      rts_n_o <= 1'b1;
    end else begin
      cfg_wr <= next_cfg_wr;
      cfg_act <= next_cfg_act;
      cfg_pending <= next_cfg_pending;
      rts <= next_rts;
      test_mode <= next_test_mode;
      fe <= next_fe;
      tx_full <= next_tx_full;
      tx_buf <= next_tx_buf;
      irq <= next_irq;
      rts_n_o <= next_rts_n;
    end
  end
  assign irq_oe_o = irq;
  assign irq_n_o = !irq;

  rx_fifo #(.W(uart_pkg::WORD_W), .D(uart_pkg::FIFO_DEPTH)) u_fifo (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .push_i(rx_push),
    .pop_i(pop),
    .flush_i(flush || (rx_push && fifo_full)),
    .one_deep_i(cfg_act.fifo_disable_n),
    .wdata_i(rx_word),
    .rdata_o(head),
    .empty_o(fifo_empty),
    .full_o(fifo_full),
    .count_o(fifo_count)
  );

  baud_gen u_baud (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .osc_rise_i(osc_rise),
    .osc_level_i(sync[5]),
    .hold_i(cfg_act.sleep_request_bit),
    .divisor_select_i(cfg_act.divisor_select),
    .tick_o(tick),
    .clk16_o(clk16)
  );

  // Word format shared by both directions.
  logic [3:0] n_data, n_bits, tx_len;
  assign n_data = cfg_act.short_word ? 4'h7 : 4'h8;
  assign n_bits = n_data + {3'h0, cfg_act.extra_bit_enable};

  // Transmitter.
  tx_state_t tx_state, next_tx_state;
  logic [11:0] tx_sr, next_tx_sr, tx_frame;
  logic [3:0] tx_left, next_tx_left, tx_phase, next_tx_phase;
  logic next_tx;

  assign tx_busy = tx_state != TX_IDLE;
  assign tx_take = tick && !tx_busy && tx_full && !cfg_pending;
  assign tx_len = n_bits + 4'h2 + {3'h0, cfg_act.stop_bits_sel};

  always_comb begin
    tx_frame = '1;
    tx_frame[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < n_data) tx_frame[i + 1] = tx_buf.rx_byte[i];
    end
    if (cfg_act.extra_bit_enable) tx_frame[int'(n_data) + 1] = tx_buf.rx_extra_bit;
    next_tx_state = tx_state;
    next_tx_sr = tx_sr;
    next_tx_left = tx_left;
    next_tx_phase = tx_phase;
    if (tx_take) begin
      next_tx_state = TX_SHIFT;
      next_tx_sr = tx_frame;
      next_tx_left = tx_len;
      next_tx_phase = '0;
    end else if (tick && tx_busy) begin
      next_tx_phase = tx_phase + 4'h1;
      if (tx_phase == 4'hF) begin
        next_tx_sr = {1'b1, tx_sr[11:1]};
        next_tx_left = tx_left - 4'h1;
        if (tx_left == 4'h1) next_tx_state = TX_IDLE;
      end
    end
    if (next_tx_state == TX_IDLE) begin
      next_tx = 1'b1;
    end else if (cfg_act.infrared_timing_sel) begin
      next_tx = next_tx_sr[0] || next_tx_phase >= uart_pkg::IR_PULSE_TICKS;
    end else begin
      next_tx = next_tx_sr[0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tx_state <= TX_IDLE;
      tx_sr <= '1;
      tx_left <= '0;
      tx_phase <= '0;
      tx_o <= 1'b1;
    end else begin
      tx_state <= next_tx_state;
      tx_sr <= next_tx_sr;
      tx_left <= next_tx_left;
      tx_phase <= next_tx_phase;
      tx_o <= next_tx;
    end
  end

  // Receiver.
  rx_state_t rx_state, next_rx_state;
  logic [8:0] rx_sr, next_rx_sr, rx_aligned;
  logic [3:0] rx_phase, next_rx_phase, rx_idx, next_rx_idx;
  logic [1:0] votes, next_votes;
  logic rx_prev, next_rx_prev, rx_bit;

  assign rx_in = test_mode ? tx_o : sync[4];
  assign rx_bit = (votes[1] & votes[0]) | (votes[1] & rx_in) | (votes[0] & rx_in);
  assign rx_aligned = rx_sr >> (4'h9 - n_bits);

  always_comb begin
    next_rx_state = rx_state;
    next_rx_sr = rx_sr;
    next_rx_phase = rx_phase;
    next_rx_idx = rx_idx;
    next_votes = votes;
    next_rx_prev = rx_prev;
    rx_push = 1'b0;
    rx_err = 1'b0;
    rx_good = 1'b0;
    rx_word.rx_byte = cfg_act.short_word ? {1'b0, rx_aligned[6:0]} : rx_aligned[7:0];
    rx_word.rx_extra_bit = cfg_act.extra_bit_enable && rx_aligned[n_data];
    if (tick && !cfg_act.sleep_request_bit) begin
      next_rx_prev = rx_in;
      if (rx_state == RX_IDLE) begin
        if (rx_prev && !rx_in) begin
          next_rx_state = RX_RUN;
          next_rx_phase = 4'h1;
          next_rx_idx = '0;
        end
      end else begin
        next_rx_phase = rx_phase + 4'h1;
        if (rx_phase >= uart_pkg::VOTE_FIRST && rx_phase < uart_pkg::VOTE_LAST) begin
          next_votes = {votes[0], rx_in};
        end
        if (rx_phase == uart_pkg::VOTE_LAST) begin
          next_rx_idx = rx_idx + 4'h1;
          if (rx_idx == 4'h0) begin
            if (rx_bit) next_rx_state = RX_IDLE;
          end else if (rx_idx <= n_bits) begin
            next_rx_sr = {rx_bit, rx_sr[8:1]};
          end else begin
            next_rx_state = RX_IDLE;
            rx_err = !rx_bit;
            rx_good = rx_bit;
            rx_push = rx_bit;
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rx_state <= RX_IDLE;
      rx_sr <= '0;
      rx_phase <= '0;
      rx_idx <= '0;
      votes <= '0;
      rx_prev <= 1'b1;
    end else begin
      rx_state <= next_rx_state;
      rx_sr <= next_rx_sr;
      rx_phase <= next_rx_phase;
      rx_idx <= next_rx_idx;
      votes <= next_votes;
      rx_prev <= next_rx_prev;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_abort;
    (cs_rise && active && bit_cnt != uart_pkg::FRAME_LAST) |=> $stable(cfg_wr) && $stable(rts) && $stable(tx_buf);
  endproperty
  a_abort: assert property (p_abort) else $error("Aborted frame changed a register.");
  property p_mask;
    mask_load ##1 1'b1 |-> cfg_act.tx_empty_irq_mask == $past(in_sr[10], 2);
  endproperty
  a_mask: assert property (p_mask) else $error("Mask not loaded at bit 16.");
  property p_flush;
    (frame_done && cmd == uart_pkg::CMD_WR_CFG) |=> fifo_empty && !tx_full && cfg_pending;
  endproperty
  a_flush: assert property (p_flush) else $error("Configuration write did not flush.");
  property p_wait;
    (cfg_pending && tx_busy && !mask_load) |=> $stable(cfg_act.divisor_select) && $stable(cfg_act.short_word);
  endproperty
  a_wait: assert property (p_wait) else $error("Settings changed during transmit.");
  property p_pop;
    (frame_done && cmd == uart_pkg::CMD_RD_DATA && fifo_count == 4'h1 && !rx_push) |=> fifo_empty ##1 !irq_oe_o
      || cfg_act.tx_empty_irq_mask || cfg_act.activity_irq_mask || cfg_act.extra_bit_irq_mask;
  endproperty
  a_pop: assert property (p_pop) else $error("Data read did not clear ready.");
  property p_over;
    (rx_push && fifo_full && !pop) |=> fifo_empty;
  endproperty
  a_over: assert property (p_over) else $error("Overflow did not flush.");
  property p_start;
    (rx_state == RX_IDLE && next_rx_state == RX_RUN) |-> !rx_in && rx_prev && tick;
  endproperty
  a_start: assert property (p_start) else $error("Start without falling edge.");
  property p_frame;
    rx_err |=> fe;
  endproperty
  a_frame: assert property (p_frame) else $error("Framing error not flagged.");
  property p_inhibit;
    (frame_done && cmd == uart_pkg::CMD_WR_DATA && word[uart_pkg::BIT_INHIBIT]) |=> $stable(tx_buf) ##1 rts_n_o == !rts
      || test_mode;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("Inhibited write loaded data.");
  property p_txstart;
    tx_take |=> ##1 !tx_o || cfg_act.infrared_timing_sel;
  endproperty
  a_txstart: assert property (p_txstart) else $error("No start bit sent.");
  c_wrcfg: cover property (frame_done && cmd == uart_pkg::CMD_WR_CFG);
  c_rddata: cover property (frame_done && cmd == uart_pkg::CMD_RD_DATA && !fifo_empty);
  c_txdone: cover property (tx_busy ##1 !tx_busy);
  c_ferr: cover property (rx_err);
endmodule // serial_host_uart

// ==== testbench/host_model.sv ====
`timescale 1ns/1ps
module host_model (
  // Clock.
  input wire logic clk_i,
  // Command port.
  input wire logic dout_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end

  task automatic wt();
    repeat (4) @(negedge clk_i);
  endtask

  // Sends n bits MSB first with a 400 ns serial clock; a short count aborts the frame.
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      din_o = tx[15-i];
      wt();
      rx[15-i] = dout_i;
      sclk_o = 1'b1;
      wt();
      sclk_o = 1'b0;
    end
    wt();
    cs_n_o = 1'b1;
    wt();
  endtask
endmodule // host_model

// ==== testbench/serial_host_uart_test.sv ====
`timescale 1ns/1ps
module serial_host_uart_test;
  localparam int LIMIT = 60000;
  logic core_clk_i, rst_n_i, osc, rx_drv, loop, cts_n;
  logic sclk, cs_n, din, dout, dout_oe, irq_n, irq_oe, tx, rts_n;
  logic [15:0] r;
  logic t;
  int n_fail, comparisons, cycles;

  serial_host_uart u_serial_host_uart (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .din_i(din), .dout_o(dout), .dout_oe_o(dout_oe), .irq_n_o(irq_n),
    .irq_oe_o(irq_oe), .oscillator_input_i(osc), .rx_i(loop ? tx : rx_drv),
    .tx_o(tx), .cts_n_i(cts_n), .rts_n_o(rts_n));

  host_model u_host_model (.clk_i(core_clk_i), .dout_i(dout), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));

  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  // The oscillator runs with its own phase.
  initial begin
    osc = 1'b0;
    #7;
    forever #200 osc = ~osc;
  end

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic pin(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic x(input logic [15:0] cmd, input logic [15:0] exp);
    u_host_model.xfer(cmd, 16, r);
    chk("reply", exp, r);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  task automatic test_done();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    rst_n_i = 1'b0;
    rx_drv = 1'b1;
    loop = 1'b0;
    cts_n = 1'b1;
    n_fail = 0;
    comparisons = 0;
    cycles = 0;
    idle(2);
    rst_n_i = 1'b1;
    idle(4);
    pin("rts_n", 1'b1, rts_n);
    pin("tx", 1'b1, tx);
    pin("dout_oe", 1'b0, dout_oe);
    x(16'h4000, 16'h4000);
    $display("test reset done");
    u_host_model.xfer(16'hC00F, 8, r);
    x(16'h4000, 16'h4000);
    x(16'hC400, 16'h4000);
    x(16'h4000, 16'h4400);
    $display("test config done");
    loop = 1'b1;
    x(16'h8055, 16'h4000);
    idle(1600);
    pin("irq_oe", 1'b1, irq_oe);
    pin("irq_n", 1'b0, irq_n);
    x(16'h0000, 16'hC055);
    x(16'h0000, 16'h4000);
    pin("irq_oe", 1'b0, irq_oe);
    $display("test loopback done");
    x(16'h8655, 16'h4000);
    pin("rts_n", 1'b0, rts_n);
    idle(1600);
    cts_n = 1'b0;
    x(16'h0000, 16'h4200);
    $display("test inhibit done");
    for (int i = 0; i < 8; i++) begin
      u_host_model.xfer(16'h8010 + 16'(i), 16, r);
      idle(1600);
    end
    x(16'h8018, 16'hC210);
    idle(1600);
    x(16'h0000, 16'h4200);
    $display("test overflow done");
    loop = 1'b0;
    rx_drv = 1'b0;
    idle(1600);
    rx_drv = 1'b1;
    idle(400);
    u_host_model.xfer(16'h0000, 16, r);
    chk("frame error", 16'h0400, r & 16'h0400);
    u_host_model.xfer(16'hC000, 16, r);
    x(16'h0000, 16'h4200);
    $display("test framing done");
    x(16'hC070, 16'h4000);
    x(16'h4001, 16'h4070);
    fork
      x(16'h81FF, 16'h4200);
      begin
        idle(40);
        t = rts_n;
        idle(4);
        pin("rts_n clock", !t, rts_n);
      end
    join
    idle(1600);
    x(16'h0000, 16'hC37F);
    pin("rts_n", 1'b1, rts_n);
    $display("test mode done");
    test_done();
  end
endmodule // serial_host_uart_test
